// [rtl/smwp_protect.sv]
// Serial front end, register map and write-protection logic of the memory.
// Assumes a mode-0 host, single data line, chip select framing each command.
// Notes on behaviour
// RULE1: read data leaves on falling clock edges
// RULE2: mode byte after address toggles continuous access
// RULE3: continuous access skips command, reuses last operation
// RULE4: both schemes also guard internal registers
// RULE5: deep sleep keeps array and settings
// RULE6: host waits power-up time before instructions
// RULE7: host keeps select high during supply ramps
// RULE8: array address is all 24 bits
// RULE9: registers decoded at their fixed addresses
// RULE10: pins all low, whole array writable
// RULE11: any pin high, selected region refuses writes
// RULE12: direction pin low, region from top
// RULE13: direction pin high, region from bottom
// RULE14: unconnected protect pins read low
// RULE15: codes one to seven pick top sizes
// RULE16: same codes pick bottom sizes from zero
// RULE17: software bits decode like the pins
// RULE18: software and pin regions are ORed
// RULE19: status bit seven arms the protect pin
// RULE20: status bit five picks software direction
// RULE21: status bits four to two size code
// RULE22: status bit one is read-only permit latch
// RULE23: register writes need latch and free pin
// RULE24: protect pin ignored in quad modes
// RULE25: refused write changes nothing, select ends it; code still clears permit latch (register writes, normal-mode array writes)
`timescale 1ns/1ps
module smwp_protect
  import smwp_pkg::*;
#(
  parameter int POWER_UP_WAIT = smwp_pkg::POWER_UP_WAIT_CYC,
  // Identity value is arbitrary
  parameter logic [31:0] DEVICE_ID = 32'h0012_3400
) (
  // System clock and reset
  input wire logic SYS_CLK,
  input wire logic NRST,
  // Serial link
  input wire logic LINK_SCK,
  input wire logic CS_N,
  input wire logic MOSI,
  output logic MISO_O,
  output logic MISO_OE,
  // Protection pins
  input wire logic [2:0] HW_REGION_SIZE_PINS,
  input wire logic HW_REGION_DIRECTION_PIN,
  input wire logic WP_N,
  input wire logic QUAD_SEL,
  // Array port
  input wire logic [7:0] ARRAY_RD_DATA,
  output logic ARRAY_WR_STB,
  output logic [smwp_pkg::ADDR_W-1:0] ARRAY_WR_ADDR,
  output logic [7:0] ARRAY_WR_DATA,
  // Status
  output logic WRITE_REFUSED,
  output logic DEEP_POWER_DOWN,
  output logic [7:0] PROTECTION_STATUS_BITS
);
  import smwp_pkg::*;

  localparam int WAIT_W = $clog2(POWER_UP_WAIT + 1);
  localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(POWER_UP_WAIT - 1);

  // Link-side state
  smwp_phase_t phase_r, phase_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [23:0] sh_r, sh_nxt;
  logic started_r, started_nxt;
  logic rd_r, rd_nxt;
  logic [31:0] tx_r, tx_nxt;
  logic [7:0] op_r, op_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [7:0] data_r, data_nxt;
  logic data_done_r, data_done_nxt;
  logic cmd_done_r, cmd_done_nxt;
  logic xip_r, xip_nxt;
  logic [7:0] last_op_r, last_op_nxt;
  logic frame_tog_r, frame_tog_nxt;
  logic miso_nxt, oe_nxt;
  logic frame_rst;
  logic [7:0] rd_s;

  // System-side state
  logic [7:0] sr_r, sr_nxt;
  logic [7:0] cr1_r, cr1_nxt;
  logic [7:0] cr2_r, cr2_nxt;
  logic pd_r, pd_nxt;
  logic seen_r, seen_nxt;
  logic cs_q_r, cs_q_nxt;
  logic ready_r, ready_nxt;
  logic [WAIT_W-1:0] wait_r, wait_nxt;
  logic stb_nxt, refused_nxt;
  logic [ADDR_W-1:0] waddr_nxt;
  logic [7:0] wdata_nxt;
  logic cs_s;
  logic quad_s, wp_s, hw_dir_s;
  logic [2:0] hw_size_s;
  logic pin_block, reg_ok, arr_prot;
  logic [7:0] sr_mask;

  smwp_region_if hw_if ();
  smwp_region_if sw_if ();

  // Register read view; system values are steady while select is low
  function automatic logic [31:0] reg_value(input logic [23:0] a);
    logic [7:0] v;
    logic [31:0] r;
    v = 8'h00;
    // RULE9: register address decode
    if (a == REG_STATUS) begin
      v = sr_r;
    end else if (a == REG_CFG1) begin
      v = cr1_r;
    end else if (a == REG_CFG2) begin
      v = cr2_r;
    end else if (a == REG_FLAG) begin
      v[FLAG_READY_BIT] = ready_r;
    end
    r = {4{v}};
    if (a == REG_IDENT) begin
      r = DEVICE_ID;
    end
    return r;
  endfunction : reg_value

  // RULE7: select high ends frame
  assign frame_rst = ~NRST | CS_N;

  // Array read data is a pin, so it is synchronised to the link clock
  smwp_sync2 #(.WIDTH(8)) u_rd_sync (
    .clk(LINK_SCK),
    .rst_n(NRST),
    .d(ARRAY_RD_DATA),
    .q(rd_s)
  );

  // Link frame decoder: command, address, mode byte, data
  always_comb begin
    phase_nxt = phase_r;
    cnt_nxt = cnt_r + 5'h01;
    sh_nxt = {sh_r[22:0], MOSI};
    started_nxt = 1'b1;
    rd_nxt = rd_r;
    tx_nxt = tx_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    data_done_nxt = data_done_r & started_r;
    cmd_done_nxt = cmd_done_r & started_r;
    xip_nxt = xip_r;
    last_op_nxt = last_op_r;
    frame_tog_nxt = frame_tog_r ^ ~started_r;
    // RULE3: frame opens with address
    if (!started_r && xip_r) begin
      op_nxt = last_op_r;
      phase_nxt = PH_ADDR;
    end else begin
      case (phase_r)
        PH_CMD: begin
          if (cnt_r == LAST_BYTE_BIT) begin
            cnt_nxt = '0;
            op_nxt = sh_nxt[7:0];
            phase_nxt = PH_IDLE;
            // RULE5: asleep, only wake counts
            if (!pd_r || sh_nxt[7:0] == OP_WAKE) begin
              case (sh_nxt[7:0])
                OP_WR_PERMIT, OP_WR_FORBID, OP_SLEEP, OP_WAKE: begin
                  cmd_done_nxt = 1'b1;
                end
                OP_RD_STATUS: begin
                  phase_nxt = PH_DATA;
                  rd_nxt = 1'b1;
                  tx_nxt = reg_value(REG_STATUS);
                end
                OP_WR_STATUS: begin
                  phase_nxt = PH_DATA;
                  rd_nxt = 1'b0;
                  addr_nxt = REG_STATUS;
                end
                OP_ARR_READ, OP_ARR_WRITE, OP_REG_READ, OP_REG_WRITE: begin
                  phase_nxt = PH_ADDR;
                end
                default: begin
                  phase_nxt = PH_IDLE;
                end
              endcase
            end
          end
        end
        PH_ADDR: begin
          if (cnt_r == LAST_ADDR_BIT) begin
            cnt_nxt = '0;
            // RULE8: full 24-bit address
            addr_nxt = sh_nxt;
            rd_nxt = (op_r == OP_REG_READ) || (op_r == OP_ARR_READ);
            tx_nxt = reg_value(sh_nxt);
            if (op_r == OP_ARR_READ || op_r == OP_ARR_WRITE) begin
              phase_nxt = PH_MODE;
            end else begin
              phase_nxt = PH_DATA;
            end
          end
        end
        PH_MODE: begin
          if (cnt_r == LAST_BYTE_BIT) begin
            cnt_nxt = '0;
            phase_nxt = PH_DATA;
            tx_nxt = {4{rd_s}};
            // RULE2: mode nibble sets or clears
            if (sh_nxt[7:4] == MODE_ON) begin
              xip_nxt = 1'b1;
              last_op_nxt = op_r;
            end else if (sh_nxt[7:4] == MODE_OFF) begin
              xip_nxt = 1'b0;
            end
          end
        end
        PH_DATA: begin
          if (rd_r) begin
            tx_nxt = {tx_r[30:0], tx_r[31]};
            if (cnt_r == LAST_BYTE_BIT) begin
              cnt_nxt = '0;
              if (op_r == OP_ARR_READ) begin
                tx_nxt = {4{rd_s}};
              end
            end
          end else if (cnt_r == LAST_BYTE_BIT) begin
            data_nxt = sh_nxt[7:0];
            data_done_nxt = 1'b1;
            phase_nxt = PH_IDLE;
          end
        end
        default: begin
          cnt_nxt = cnt_r;
        end
      endcase
    end
  end

  // Frame-scoped link state, cleared whenever select is high
  always_ff @(posedge LINK_SCK or posedge frame_rst) begin
    if (frame_rst) begin
      phase_r <= PH_CMD;
      cnt_r <= '0;
      sh_r <= '0;
      started_r <= 1'b0;
      rd_r <= 1'b0;
      tx_r <= '0;
    end else begin
      phase_r <= phase_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      started_r <= started_nxt;
      rd_r <= rd_nxt;
      tx_r <= tx_nxt;
    end
  end

  // Captured frame, kept after select rises for the system side
  always_ff @(posedge LINK_SCK or negedge NRST) begin
    if (!NRST) begin
      op_r <= '0;
      addr_r <= '0;
      data_r <= '0;
      data_done_r <= 1'b0;
      cmd_done_r <= 1'b0;
      xip_r <= 1'b0;
      last_op_r <= '0;
      frame_tog_r <= 1'b0;
    end else begin
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      data_done_r <= data_done_nxt;
      cmd_done_r <= cmd_done_nxt;
      xip_r <= xip_nxt;
      last_op_r <= last_op_nxt;
      frame_tog_r <= frame_tog_nxt;
    end
  end

  // Output bit and enable
  always_comb begin
    miso_nxt = tx_r[31];
    oe_nxt = (phase_r == PH_DATA) && rd_r;
  end

  // RULE1: launch on falling edge
  always_ff @(negedge LINK_SCK or posedge frame_rst) begin
    if (frame_rst) begin
      MISO_O <= 1'b0;
      MISO_OE <= 1'b0;
    end else begin
      MISO_O <= miso_nxt;
      MISO_OE <= oe_nxt;
    end
  end

  // Select and protection pins into the system domain
  smwp_sync2 #(.WIDTH(1)) u_cs_sync (
    .clk(SYS_CLK),
    .rst_n(NRST),
    .d(CS_N),
    .q(cs_s)
  );
  smwp_sync2 #(.WIDTH(6)) u_pin_sync (
    .clk(SYS_CLK),
    .rst_n(NRST),
    .d({QUAD_SEL, WP_N, HW_REGION_DIRECTION_PIN, HW_REGION_SIZE_PINS}),
    .q({quad_s, wp_s, hw_dir_s, hw_size_s})
  );

  // RULE11: pin region query
  // RULE14: floating pins arrive low
  assign hw_if.code = hw_size_s;
  assign hw_if.dir = hw_dir_s;
  assign hw_if.addr = addr_r;
  // RULE17: software bits, same decoder
  // RULE20: direction from status
  // RULE21: size code from status
  assign sw_if.code = sr_r[SR_SIZE_LO +: 3];
  assign sw_if.dir = sr_r[SR_DIR];
  assign sw_if.addr = addr_r;

  smwp_region_decode u_hw_dec (.rgn(hw_if));
  smwp_region_decode u_sw_dec (.rgn(sw_if));

  // RULE18: either source protects
  assign arr_prot = hw_if.hit | sw_if.hit;
  // RULE19: armed pin protection
  // RULE24: quad mode disables pin
  assign pin_block = sr_r[SR_PIN_EN] & ~wp_s & ~quad_s;
  // RULE4: register guard
  // RULE23: latch and free pin
  assign reg_ok = sr_r[SR_LATCH] & ~pin_block;
  // Region bits freeze when the lock bit is set
  assign sr_mask = cr1_r[CR1_LOCK] ? (SR_WR_MASK & ~SR_REGION_MASK) : SR_WR_MASK;

  // Executes each completed frame once, after select has risen
  always_comb begin
    sr_nxt = sr_r;
    cr1_nxt = cr1_r;
    cr2_nxt = cr2_r;
    pd_nxt = pd_r;
    seen_nxt = seen_r;
    cs_q_nxt = cs_s;
    ready_nxt = ready_r;
    wait_nxt = wait_r;
    stb_nxt = 1'b0;
    refused_nxt = 1'b0;
    waddr_nxt = ARRAY_WR_ADDR;
    wdata_nxt = ARRAY_WR_DATA;
    // RULE6: frames before wait ignored
    if (!ready_r) begin
      if (wait_r == WAIT_LAST) begin
        ready_nxt = 1'b1;
      end else begin
        wait_nxt = wait_r + 1'b1;
      end
    end
    if (cs_s && !cs_q_r && frame_tog_r != seen_r) begin
      seen_nxt = frame_tog_r;
      if (!ready_r) begin
        seen_nxt = frame_tog_r;
      end else if (pd_r) begin
        // RULE5: wake leaves settings intact
        if (cmd_done_r && op_r == OP_WAKE) begin
          pd_nxt = 1'b0;
        end
      end else if (cmd_done_r) begin
        case (op_r)
          OP_WR_PERMIT: sr_nxt[SR_LATCH] = 1'b1;
          OP_WR_FORBID: sr_nxt[SR_LATCH] = 1'b0;
          OP_SLEEP: pd_nxt = 1'b1;
          default: pd_nxt = pd_r;
        endcase
      end else if (data_done_r && op_r == OP_ARR_WRITE) begin
        // RULE25: refused, nothing written
        if (arr_prot) begin
          refused_nxt = 1'b1;
        end else if (sr_r[SR_LATCH] || cr1_r[CR1_WRENS_LO +: 2] == WRENS_SRAM) begin
          stb_nxt = 1'b1;
          waddr_nxt = addr_r;
          wdata_nxt = data_r;
        end else begin
          refused_nxt = 1'b1;
        end
        if (cr1_r[CR1_WRENS_LO +: 2] == WRENS_NORMAL) begin
          sr_nxt[SR_LATCH] = 1'b0;
        end
      end else if (data_done_r) begin
        // RULE25: refused register write
        if (!reg_ok) begin
          refused_nxt = 1'b1;
        end else if (addr_r == REG_STATUS) begin
          // RULE22: latch and reserved bits kept
          sr_nxt = (sr_r & ~sr_mask) | (data_r & sr_mask);
        end else if (addr_r == REG_CFG1) begin
          cr1_nxt = (cr1_r & ~CR1_WR_MASK) | (data_r & CR1_WR_MASK);
        end else if (addr_r == REG_CFG2) begin
          cr2_nxt = (cr2_r & ~CR2_WR_MASK) | (data_r & CR2_WR_MASK);
        end
        sr_nxt[SR_LATCH] = 1'b0;
      end
    end
  end

  // System-side registers and outputs
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      sr_r <= SR_RESET;
      cr1_r <= CR1_RESET;
      cr2_r <= CR2_RESET;
      pd_r <= 1'b0;
      seen_r <= 1'b0;
      cs_q_r <= 1'b1;
      ready_r <= 1'b0;
      wait_r <= '0;
      ARRAY_WR_STB <= 1'b0;
      ARRAY_WR_ADDR <= '0;
      ARRAY_WR_DATA <= '0;
      WRITE_REFUSED <= 1'b0;
      DEEP_POWER_DOWN <= 1'b0;
      PROTECTION_STATUS_BITS <= SR_RESET;
    end else begin
      sr_r <= sr_nxt;
      cr1_r <= cr1_nxt;
      cr2_r <= cr2_nxt;
      pd_r <= pd_nxt;
      seen_r <= seen_nxt;
      cs_q_r <= cs_q_nxt;
      ready_r <= ready_nxt;
      wait_r <= wait_nxt;
      ARRAY_WR_STB <= stb_nxt;
      ARRAY_WR_ADDR <= waddr_nxt;
      ARRAY_WR_DATA <= wdata_nxt;
      WRITE_REFUSED <= refused_nxt;
      DEEP_POWER_DOWN <= pd_nxt;
      PROTECTION_STATUS_BITS <= sr_nxt;
    end
  end
endmodule : smwp_protect

// [pkg/smwp_pkg.sv]
// Constants, opcodes and field layout for the write-protect block.
// Assumes a 24-bit array address and one-byte registers, except identity.
package smwp_pkg;
  // Widths and clock rate
  localparam int ADDR_W = 24;
  localparam int REGION_BITS = 6;
  localparam int SYS_CLK_MHZ = 200;
  // Power-up wait in microseconds, then in system clock cycles
  localparam int POWER_UP_WAIT_US = 250;
  localparam int POWER_UP_WAIT_CYC = POWER_UP_WAIT_US * SYS_CLK_MHZ;

  // Instruction opcodes
  localparam logic [7:0] OP_WR_PERMIT = 8'h06;
  localparam logic [7:0] OP_WR_FORBID = 8'h04;
  localparam logic [7:0] OP_RD_STATUS = 8'h05;
  localparam logic [7:0] OP_WR_STATUS = 8'h01;
  localparam logic [7:0] OP_ARR_READ = 8'h03;
  localparam logic [7:0] OP_ARR_WRITE = 8'h02;
  localparam logic [7:0] OP_REG_READ = 8'h65;
  localparam logic [7:0] OP_REG_WRITE = 8'h71;
  localparam logic [7:0] OP_SLEEP = 8'hb9;
  localparam logic [7:0] OP_WAKE = 8'hab;

  // Mode byte upper nibbles
  localparam logic [3:0] MODE_ON = 4'ha;
  localparam logic [3:0] MODE_OFF = 4'hf;

  // Register addresses
  localparam logic [23:0] REG_STATUS = 24'h000000;
  localparam logic [23:0] REG_CFG1 = 24'h000002;
  localparam logic [23:0] REG_CFG2 = 24'h000003;
  localparam logic [23:0] REG_INT_CFG = 24'h000004;
  localparam logic [23:0] REG_TEST_IN = 24'h000005;
  localparam logic [23:0] REG_TEST_MASK = 24'h000006;
  localparam logic [23:0] REG_TEST_OUT = 24'h000007;
  localparam logic [23:0] REG_ERR_COUNT = 24'h000008;
  localparam logic [23:0] REG_FLAG = 24'h00000a;
  localparam logic [23:0] REG_IDENT = 24'h000030;

  // Status fields
  localparam int SR_PIN_EN = 7;
  localparam int SR_DIR = 5;
  localparam int SR_SIZE_LO = 2;
  localparam int SR_LATCH = 1;
  localparam logic [7:0] SR_RESET = 8'h00;
  localparam logic [7:0] SR_WR_MASK = 8'hbc;
  localparam logic [7:0] SR_REGION_MASK = 8'h3c;
  // Configuration fields
  localparam logic [7:0] CR1_RESET = 8'hc0;
  localparam logic [7:0] CR1_WR_MASK = 8'he7;
  localparam int CR1_LOCK = 2;
  localparam int CR1_WRENS_LO = 0;
  localparam logic [1:0] WRENS_NORMAL = 2'h0;
  localparam logic [1:0] WRENS_SRAM = 2'h1;
  localparam logic [7:0] CR2_RESET = 8'h08;
  localparam logic [7:0] CR2_WR_MASK = 8'h1f;
  localparam int FLAG_READY_BIT = 7;

  // Region codes
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_FULL = 3'h7;

  // Bit counters
  localparam logic [4:0] LAST_BYTE_BIT = 5'h07;
  localparam logic [4:0] LAST_ADDR_BIT = 5'h17;

  // Frame phases on the link clock
  typedef enum logic [4:0] {
    PH_CMD = 5'h01,
    PH_ADDR = 5'h02,
    PH_MODE = 5'h04,
    PH_DATA = 5'h08,
    PH_IDLE = 5'h10
  } smwp_phase_t;
endpackage : smwp_pkg

// [pkg/smwp_region_if.sv]
// Carrier between the top and a region decoder: code, direction, address, hit.
// Assumes the decoder is purely combinational.
`timescale 1ns/1ps
interface smwp_region_if;
  logic [2:0] code;
  logic dir;
  logic [23:0] addr;
  logic hit;
  modport decoder (input code, input dir, input addr, output hit);
  modport user (output code, output dir, output addr, input hit);
endinterface : smwp_region_if

// [rtl/smwp_sync2.sv]
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; multi-bit words must be quasi-static.
`timescale 1ns/1ps
module smwp_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] q_nxt;

  // First stage feeds only the second
  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  // Both stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= meta_nxt;
      q <= q_nxt;
    end
  end
endmodule : smwp_sync2

// [rtl/smwp_region_decode.sv]
// Protected-region decoder: a three-bit size code and a direction bit.
// Assumes the address is stable while the hit is used.
`timescale 1ns/1ps
module smwp_region_decode (
  // Region query
  smwp_region_if.decoder rgn
);
  import smwp_pkg::*;

  logic [2:0] span;
  logic [REGION_BITS-1:0] bit_ok;

  // RULE15: size from code
  // Code 1 checks six top bits (1/64), code 6 checks one bit (1/2)
  assign span = 3'(CODE_FULL - rgn.code);

  // RULE12: top region needs ones
  // RULE13: bottom region needs zeros
  for (genvar g = 0; g < REGION_BITS; g++) begin : g_bit
    assign bit_ok[g] = (3'(g) >= span) || (rgn.addr[ADDR_W-1-g] != rgn.dir);
  end

  // RULE10: code zero protects nothing
  // RULE16: bottom sizes mirror top
  assign rgn.hit = (rgn.code == CODE_FULL) || ((rgn.code != CODE_NONE) && (&bit_ok));
endmodule : smwp_region_decode

// [tb/smwp_protect_assertions.sv]
// Concurrent checks on the top-level ports of the write-protect block.
// Assumes the pins stay still for several cycles around every frame.
`timescale 1ns/1ps
module smwp_protect_checker (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic NRST,
  // Link and pins
  input wire logic CS_N,
  input wire logic MISO_OE,
  input wire logic [2:0] HW_REGION_SIZE_PINS,
  input wire logic HW_REGION_DIRECTION_PIN,
  input wire logic WP_N,
  input wire logic QUAD_SEL,
  // Results
  input wire logic ARRAY_WR_STB,
  input wire logic [23:0] ARRAY_WR_ADDR,
  input wire logic WRITE_REFUSED,
  input wire logic DEEP_POWER_DOWN,
  input wire logic [7:0] PROTECTION_STATUS_BITS
);
  // Region is 2**(17+code) bytes; code 7 shifts the mask out entirely
  function automatic logic in_rgn(logic [2:0] c, logic d, logic [23:0] a);
    logic [23:0] m;
    m = 24'hffffff << (17 + c);
    return (c != 3'h0) && (d ? ((a & m) == 24'h000000) : ((a & m) == m));
  endfunction : in_rgn
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);
  property p_stb_one;
    ARRAY_WR_STB |=> !ARRAY_WR_STB;
  endproperty
  a_stb_one: assert property (p_stb_one) else $error("write strobe too long");
  property p_ref_one;
    $rose(WRITE_REFUSED) |-> ##1 !WRITE_REFUSED;
  endproperty
  a_ref_one: assert property (p_ref_one) else $error("refusal pulse too long");
  property p_excl;
    !(ARRAY_WR_STB && WRITE_REFUSED);
  endproperty
  a_excl: assert property (p_excl) else $error("write both taken and refused");
  property p_hw_rgn;
    ARRAY_WR_STB |->
      !in_rgn(HW_REGION_SIZE_PINS, HW_REGION_DIRECTION_PIN, ARRAY_WR_ADDR);
  endproperty
  a_hw_rgn: assert property (p_hw_rgn) else $error("write inside pin region");
  property p_sw_rgn;
    ARRAY_WR_STB |->
      !in_rgn(PROTECTION_STATUS_BITS[4:2], PROTECTION_STATUS_BITS[5], ARRAY_WR_ADDR);
  endproperty
  a_sw_rgn: assert property (p_sw_rgn) else $error("write inside status region");
  property p_oe_idle;
    CS_N && $past(CS_N) |-> !MISO_OE;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("data out while deselected");
  // Pin lock: guard of 8 cycles covers the pin synchroniser
  property p_wp;
    PROTECTION_STATUS_BITS[7] && !WP_N && !QUAD_SEL && !$past(WP_N, 8) && !$past(QUAD_SEL, 8)
      |=> $stable(PROTECTION_STATUS_BITS[7:2]);
  endproperty
  a_wp: assert property (p_wp) else $error("status changed while pin locked");
  property p_sleep;
    DEEP_POWER_DOWN && $past(DEEP_POWER_DOWN)
      |-> $stable(PROTECTION_STATUS_BITS) && !ARRAY_WR_STB && !WRITE_REFUSED;
  endproperty
  a_sleep: assert property (p_sleep) else $error("activity while asleep");
  c_write: cover property (ARRAY_WR_STB);
  c_refuse: cover property (WRITE_REFUSED && PROTECTION_STATUS_BITS[4:2] != 3'h0);
  c_sleep: cover property ($rose(DEEP_POWER_DOWN));
endmodule : smwp_protect_checker
bind smwp_protect smwp_protect_checker u_chk (
  .SYS_CLK, .NRST, .CS_N, .MISO_OE, .HW_REGION_SIZE_PINS, .HW_REGION_DIRECTION_PIN,
  .WP_N, .QUAD_SEL, .ARRAY_WR_STB, .ARRAY_WR_ADDR, .WRITE_REFUSED, .DEEP_POWER_DOWN,
  .PROTECTION_STATUS_BITS
);

// [tb/smwp_host_model.sv]
// Host controller model on the link: mode 0, one data line, MSB first.
// Assumes the bench calls frame from a single process at a time.
`timescale 1ns/1ps
module smwp_host_model (
  // Link to the device
  output logic sck,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // Clock runs only inside a frame, 32 ns period
  task automatic frame(input logic [63:0] d, input int n, output logic [31:0] rx);
    rx = 32'h00000000;
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi = d[i];
      #16;
      sck = 1'b1;
      rx = {rx[30:0], miso};
      #16;
      sck = 1'b0;
    end
    #16;
    cs_n = 1'b1;
    // Released line shows the inverse, never a stale copy
    mosi = ~mosi;
    // Gap well above the minimum deselect time
    #100;
  endtask : frame
endmodule : smwp_host_model

// [tb/tb_top.sv]
// Self-checking bench: host model on the link, pins and reset driven here.
// Assumes the host model is the only driver of the link signals.
`timescale 1ns/1ps
module tb_top;
  import smwp_pkg::*;
  localparam int PW = 20;
  // Arbitrary identity value
  localparam logic [31:0] ID = 32'h00a5_5a00;
  logic clk, nrst, sck, cs_n, mosi, mo, moe, quad, wp_n, hdir, stb, refd, dpd, free;
  logic [2:0] hcode;
  logic [7:0] rdd, sr, wd, esr;
  logic [23:0] wa, a, b;
  logic [31:0] rx;
  wire miso;
  int n_errors = 0;
  int checks = 0;
  int n_stb = 0;
  int n_ref = 0;
  int k, n0;
  // Released line shows the inverse, so a stray read cannot match
  assign miso = moe ? mo : ~mo;
  smwp_protect #(.POWER_UP_WAIT(PW), .DEVICE_ID(ID)) u_dut (
    .SYS_CLK(clk), .NRST(nrst), .LINK_SCK(sck), .CS_N(cs_n), .MOSI(mosi), .MISO_O(mo),
    .MISO_OE(moe), .HW_REGION_SIZE_PINS(hcode), .HW_REGION_DIRECTION_PIN(hdir),
    .WP_N(wp_n), .QUAD_SEL(quad), .ARRAY_RD_DATA(rdd), .ARRAY_WR_STB(stb),
    .ARRAY_WR_ADDR(wa), .ARRAY_WR_DATA(wd), .WRITE_REFUSED(refd),
    .DEEP_POWER_DOWN(dpd), .PROTECTION_STATUS_BITS(sr));
  smwp_host_model u_host (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Pulses counted here, so checks may follow the frame
  always @(posedge clk) begin
    if (stb === 1'b1) n_stb++;
    if (refd === 1'b1) n_ref++;
  end
  function automatic logic in_rgn(logic [2:0] c, logic d, logic [23:0] ad);
    logic [23:0] m;
    m = 24'hffffff << (17 + c);
    return (c != 3'h0) && (d ? ((ad & m) == 24'h000000) : ((ad & m) == m));
  endfunction : in_rgn
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic run(input logic [63:0] d, input int n);
    u_host.frame(d, n, rx);
  endtask : run
  task automatic rd_reg(input logic [23:0] ad, input logic [7:0] v);
    run(64'({OP_REG_READ, ad, 8'h00}), 40);
    chk("register read", 32'(v), 32'(rx[7:0]));
  endtask : rd_reg
  // Permit then register write; ok says whether it must be taken
  task automatic wr_chk(input logic [23:0] ad, input logic [7:0] v, input logic ok);
    int r0;
    r0 = n_ref;
    run(64'(OP_WR_PERMIT), 8);
    run(64'({OP_REG_WRITE, ad, v}), 40);
    if (ok && ad == REG_STATUS) esr = v & 8'hbc;
    chk("register refusal", 32'(!ok), 32'(n_ref - r0));
    chk("status", 32'(esr), 32'(sr & 8'hbc));
  endtask : wr_chk
  // One array write, in continuous form when sk is set
  task automatic aw(input logic [23:0] ad, input logic pm, input logic [7:0] md,
                    input logic sk);
    int s0;
    int r0;
    logic ok;
    logic [7:0] v;
    v = 8'($urandom);
    s0 = n_stb;
    r0 = n_ref;
    ok = !in_rgn(hcode, hdir, ad) && !in_rgn(esr[4:2], esr[5], ad) && (pm || free);
    if (pm) run(64'(OP_WR_PERMIT), 8);
    if (sk) run(64'({ad, md, v}), 40);
    else run(64'({OP_ARR_WRITE, ad, md, v}), 48);
    chk("strobes", 32'(ok), 32'(n_stb - s0));
    chk("refusals", 32'(!ok), 32'(n_ref - r0));
    if (ok) chk("address", 32'(ad), 32'(wa));
    if (ok) chk("data", 32'(v), 32'(wd));
  endtask : aw
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  // Limit about three times the expected run
  initial begin
    #400_000;
    n_errors++;
    final_report;
  end
  initial begin
    nrst = 1'b0;
    quad = 1'b0;
    wp_n = 1'b1;
    hdir = 1'b0;
    hcode = 3'h0;
    rdd = 8'h00;
    esr = 8'h00;
    free = 1'b0;
    void'($urandom(8033));
    repeat (6) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    repeat (PW + 4) @(posedge clk);
    chk("reset status", 32'h0, 32'(sr));
    run(64'({OP_RD_STATUS, 8'h00}), 16);
    chk("status read", 32'h0, 32'(rx[7:0]));
    rd_reg(REG_CFG1, CR1_RESET);
    rd_reg(REG_CFG2, CR2_RESET);
    rd_reg(REG_TEST_IN, 8'h00);
    rd_reg(REG_FLAG, 8'h80);
    run({OP_REG_READ, REG_IDENT, 32'h0}, 64);
    chk("identity", ID, rx);
    $display("test reset_and_map done");
    run(64'(OP_WR_PERMIT), 8);
    chk("permit latch", 32'h1, 32'(sr[1]));
    wr_chk(REG_STATUS, 8'hff, 1'b1);
    chk("reserved and latch", 32'hbc, 32'(sr));
    n0 = n_ref;
    run(64'({OP_WR_STATUS, 8'h00}), 16);
    chk("unlatched write", 32'(n0 + 1), 32'(n_ref));
    aw(24'($urandom), 1'b1, 8'h00, 1'b0);
    wr_chk(REG_STATUS, 8'h00, 1'b1);
    $display("test status_bits done");
    for (int i = 0; i < 24; i++) begin
      @(negedge clk);
      hcode = 3'(i);
      hdir = 1'($urandom);
      wr_chk(REG_STATUS, {2'b00, 1'($urandom), 3'(i / 3), 2'b00}, 1'b1);
      k = $urandom % 5;
      b = 24'h000001 << (18 + $urandom % 6);
      a = (k == 0) ? 24'($urandom) : (k == 1) ? b - 24'h1 : (k == 2) ? b : -b;
      aw(a, ($urandom % 4) != 0, 8'h00, 1'b0);
    end
    $display("test regions done");
    @(negedge clk);
    hcode = 3'h0;
    wr_chk(REG_STATUS, 8'h80, 1'b1);
    @(negedge clk);
    wp_n = 1'b0;
    wr_chk(REG_STATUS, 8'h84, 1'b0);
    aw(24'h000100, 1'b1, 8'h00, 1'b0);
    @(negedge clk);
    quad = 1'b1;
    wr_chk(REG_STATUS, 8'h04, 1'b1);
    @(negedge clk);
    quad = 1'b0;
    wp_n = 1'b1;
    $display("test pin_lock done");
    wr_chk(REG_CFG1, 8'hc1, 1'b1);
    rd_reg(REG_CFG1, 8'hc1);
    free = 1'b1;
    aw(24'h123456, 1'b0, 8'ha0, 1'b0);
    aw(24'h654321, 1'b0, 8'hf0, 1'b1);
    aw(24'h00abcd, 1'b0, 8'h00, 1'b0);
    @(negedge clk);
    rdd = 8'($urandom);
    run(64'({OP_ARR_READ, 24'h000040, 8'h00, 8'h00}), 48);
    chk("array read", 32'(rdd), 32'(rx[7:0]));
    free = 1'b0;
    wr_chk(REG_CFG1, CR1_RESET, 1'b1);
    $display("test continuous done");
    run(64'(OP_SLEEP), 8);
    chk("asleep", 32'h1, 32'(dpd));
    n0 = n_ref + n_stb;
    run(64'({OP_WR_STATUS, 8'hbc}), 16);
    chk("ignored asleep", 32'(n0), 32'(n_ref + n_stb));
    run(64'(OP_WAKE), 8);
    chk("awake", 32'h0, 32'(dpd));
    chk("status kept", 32'(esr), 32'(sr & 8'hbc));
    aw(24'h000200, 1'b1, 8'h00, 1'b0);
    $display("test sleep done");
    final_report;
  end
endmodule : tb_top
